// ---- rtl/exc_entry_pkg.sv ----
// constants and types for the exception entry unit
package exc_entry_pkg;

    localparam int          STATUS_W      = 8;
    localparam int          BIT_IMASK     = 7;
    localparam int          BIT_FMASK     = 6;
    localparam int          BIT_COMP      = 5;
    localparam logic [4:0]  MODE_USER     = 5'h10;
    localparam logic [4:0]  MODE_FAST     = 5'h11;
    localparam logic [4:0]  MODE_IRQ      = 5'h12;
    localparam logic [4:0]  MODE_SUPER    = 5'h13;
    localparam logic [4:0]  MODE_ABORT    = 5'h17;
    localparam logic [4:0]  MODE_UNDEF    = 5'h1B;
    localparam logic [4:0]  MODE_SYSTEM   = 5'h1F;
    localparam logic [7:0]  STATUS_RESET  = 8'hD3;

    localparam logic [31:0] VEC_RESET     = 32'h0000_0000;
    localparam logic [31:0] VEC_UNDEF     = 32'h0000_0004;
    localparam logic [31:0] VEC_TRAP      = 32'h0000_0008;
    localparam logic [31:0] VEC_PABORT    = 32'h0000_000C;
    localparam logic [31:0] VEC_DABORT    = 32'h0000_0010;
    localparam logic [31:0] VEC_RESERVED  = 32'h0000_0014;
    localparam logic [31:0] VEC_IRQ       = 32'h0000_0018;
    localparam logic [31:0] VEC_FAST      = 32'h0000_001C;

    localparam logic [31:0] OFS_2         = 32'h0000_0002;
    localparam logic [31:0] OFS_4         = 32'h0000_0004;
    localparam logic [31:0] OFS_8         = 32'h0000_0008;

    // register map over the bus
    localparam logic [11:0] ADDR_CTRL     = 12'h000;
    localparam logic [11:0] ADDR_STATUS   = 12'h004;
    localparam logic [11:0] ADDR_SAVED    = 12'h008;
    localparam logic [11:0] ADDR_VECTOR   = 12'h00C;
    localparam logic [11:0] ADDR_LINK     = 12'h010;
    localparam logic [11:0] ADDR_CAUSE    = 12'h014;
    localparam logic [11:0] ADDR_PC       = 12'h018;

    typedef enum logic [2:0] {
        EXC_NONE,
        EXC_RESET,
        EXC_DABORT,
        EXC_FAST,
        EXC_IRQ,
        EXC_PABORT,
        EXC_UNDEF,
        EXC_TRAP
    } exc_t;

endpackage

// ---- rtl/exc_entry_unit.sv ----
// exception entry sequencer with apb status and control registers
`timescale 1ns/1ps
`default_nettype none
module exc_entry_unit
    import exc_entry_pkg::*;
(
    // apb
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // interrupt inputs
    input  wire logic        fast_irq_n,
    input  wire logic        normal_irq_n,
    // pipeline events
    input  wire logic        instr_end,
    input  wire logic [31:0] instr_pc,
    input  wire logic        data_abort,
    input  wire logic        prefetch_abort_at_exec,
    input  wire logic        undef_instr,
    input  wire logic        software_trap,
    input  wire logic        exc_return,
    // core redirection
    output logic             vector_load,
    output logic      [31:0] vector_addr,
    output logic      [4:0]  exc_mode,
    output logic             data_squash,
    output logic             core_locked
);
    import exc_entry_pkg::*;

    typedef struct packed {
        logic [1:0]          fsync;
        logic [STATUS_W-1:0] current_status_word;
        logic [STATUS_W-1:0] saved_status_word;
        logic [31:0]         return_link_reg;
        logic [31:0]         abort_link;
        logic [31:0]         fast_mode_link;
        logic [31:0]         interrupt_mode_link;
        logic [31:0]         undefined_mode_link;
        logic [31:0]         supervisor_link;
        logic [31:0]         pc;
        logic                pend_fast;
        logic                vload;
        logic [31:0]         vaddr;
        logic                squash;
        logic                locked;
        exc_t                cause;
        logic [31:0]         rdata;
    } state_t;

    state_t s;
    state_t next_s;

    // --------------------------------------------------------------
    // helpers
    // --------------------------------------------------------------
    function automatic logic mode_valid(input logic [4:0] m);
        return m == MODE_USER || m == MODE_FAST || m == MODE_IRQ ||
               m == MODE_SUPER || m == MODE_ABORT ||
               m == MODE_UNDEF || m == MODE_SYSTEM;
    endfunction

    // status word after entry: mode, interrupt mask (fast mask on fast entry only), compressed bit cleared
    function automatic logic [STATUS_W-1:0] enter_word(
        input logic [STATUS_W-1:0] cur,
        input logic [4:0]          mode,
        input logic                set_fast);
        logic [STATUS_W-1:0] w;
        w = cur;
        w[4:0] = mode;
        w[BIT_COMP] = 1'b0;
        w[BIT_IMASK] = 1'b1;
        if (set_fast)
        begin
            w[BIT_FMASK] = 1'b1;
        end
        return w;
    endfunction

    // link step for traps, half a word in compressed state
    function automatic logic [31:0] trap_ofs(input logic compressed);
        logic [31:0] o;
        o = OFS_4;
        if (compressed)
        begin
            o = OFS_2;
        end
        return o;
    endfunction

    // any address up to ADDR_PC, the last word of the register map
    function automatic logic addr_mapped(input logic [11:0] a);
        return a <= ADDR_PC;
    endfunction

    // vector of each entry; the reserved slot is never produced
    function automatic logic [31:0] vector_of(input exc_t k);
        logic [31:0] v;
        case (k)
            EXC_UNDEF:  v = VEC_UNDEF;
            EXC_TRAP:   v = VEC_TRAP;
            EXC_PABORT: v = VEC_PABORT;
            EXC_DABORT: v = VEC_DABORT;
            EXC_IRQ:    v = VEC_IRQ;
            EXC_FAST:   v = VEC_FAST;
            default:    v = VEC_RESET;
        endcase
        return v;
    endfunction

    // register read mux, unmapped words read as zero
    function automatic logic [31:0] read_word(
        input logic [11:0] a,
        input state_t      st);
        logic [31:0] d;
        d = 32'h0000_0000;
        if (a == ADDR_CTRL)
        begin
            d = {31'h0, st.locked};
        end
        else if (a == ADDR_STATUS)
        begin
            d = {24'h00_0000, st.current_status_word};
        end
        else if (a == ADDR_SAVED)
        begin
            d = {24'h00_0000, st.saved_status_word};
        end
        else if (a == ADDR_VECTOR)
        begin
            d = st.vaddr;
        end
        else if (a == ADDR_LINK)
        begin
            d = st.return_link_reg;
        end
        else if (a == ADDR_CAUSE)
        begin
            d = {29'h0, st.cause};
        end
        else if (a == ADDR_PC)
        begin
            d = st.pc;
        end
        return d;
    endfunction

    // priority of entries pending in the same cycle
    function automatic exc_t pick_entry(
        input logic dab,
        input logic fst,
        input logic irq,
        input logic pab,
        input logic und,
        input logic trp);
        exc_t k;
        if (dab)
        begin
            k = EXC_DABORT;
        end
        else if (fst)
        begin
            k = EXC_FAST;
        end
        else if (irq)
        begin
            k = EXC_IRQ;
        end
        else if (pab)
        begin
            k = EXC_PABORT;
        end
        else if (trp)
        begin
            k = EXC_TRAP;
        end
        else if (und)
        begin
            k = EXC_UNDEF;
        end
        else
        begin
            k = EXC_NONE;
        end
        return k;
    endfunction

    logic comp;
    logic fast_req;
    logic irq_req;
    exc_t entry;
    logic acc;

    // --------------------------------------------------------------
    // next state
    // --------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.vload = 1'b0;
        next_s.squash = 1'b0;
        comp = s.current_status_word[BIT_COMP];
        acc = psel && penable;
        next_s.fsync = {s.fsync[0], fast_irq_n};
        // fast interrupt sampled at instruction end, and on data abort entry
        fast_req = instr_end && !s.fsync[1] &&
                   !s.current_status_word[BIT_FMASK];
        irq_req = instr_end && !normal_irq_n &&
                  !s.current_status_word[BIT_IMASK];
        // one entry per cycle, highest priority first
        entry = pick_entry(data_abort, s.pend_fast || fast_req, irq_req,
                           prefetch_abort_at_exec, undef_instr,
                           software_trap);

        if (instr_end)
        begin
            next_s.pc = instr_pc;
        end

        if (s.locked)
        begin
            next_s.locked = 1'b1;
        end
        else if (entry == EXC_DABORT)
        begin
            next_s.squash = 1'b1;
            next_s.abort_link = instr_pc + OFS_8;
            next_s.return_link_reg = instr_pc + OFS_8;
            next_s.saved_status_word = s.current_status_word;
            next_s.current_status_word =
                enter_word(s.current_status_word, MODE_ABORT, 1'b0);
            next_s.vload = 1'b1;
            next_s.cause = EXC_DABORT;
            // unmasked fast interrupt follows straight after
            next_s.pend_fast = !s.fsync[1] &&
                               !s.current_status_word[BIT_FMASK];
        end
        else if (entry == EXC_FAST)
        begin
            next_s.pend_fast = 1'b0;
            next_s.fast_mode_link = (s.pend_fast ? VEC_DABORT : instr_pc)
                                    + OFS_4;
            next_s.return_link_reg = next_s.fast_mode_link;
            next_s.saved_status_word = s.current_status_word;
            next_s.current_status_word =
                enter_word(s.current_status_word, MODE_FAST, 1'b1);
            next_s.vload = 1'b1;
            next_s.cause = EXC_FAST;
        end
        else if (entry == EXC_IRQ)
        begin
            next_s.interrupt_mode_link = instr_pc + OFS_4;
            next_s.return_link_reg = instr_pc + OFS_4;
            next_s.saved_status_word = s.current_status_word;
            next_s.current_status_word =
                enter_word(s.current_status_word, MODE_IRQ, 1'b0);
            next_s.vload = 1'b1;
            next_s.cause = EXC_IRQ;
        end
        else if (entry == EXC_PABORT)
        begin
            next_s.abort_link = instr_pc + OFS_4;
            next_s.return_link_reg = instr_pc + OFS_4;
            next_s.saved_status_word = s.current_status_word;
            next_s.current_status_word =
                enter_word(s.current_status_word, MODE_ABORT, 1'b0);
            next_s.vload = 1'b1;
            next_s.cause = EXC_PABORT;
        end
        else if (entry == EXC_UNDEF)
        begin
            next_s.undefined_mode_link = instr_pc + trap_ofs(comp);
            next_s.return_link_reg = next_s.undefined_mode_link;
            next_s.saved_status_word = s.current_status_word;
            next_s.current_status_word =
                enter_word(s.current_status_word, MODE_UNDEF, 1'b0);
            next_s.vload = 1'b1;
            next_s.cause = EXC_UNDEF;
        end
        else if (entry == EXC_TRAP)
        begin
            next_s.supervisor_link = instr_pc + trap_ofs(comp);
            next_s.return_link_reg = next_s.supervisor_link;
            next_s.saved_status_word = s.current_status_word;
            next_s.current_status_word =
                enter_word(s.current_status_word, MODE_SUPER, 1'b0);
            next_s.vload = 1'b1;
            next_s.cause = EXC_TRAP;
        end
        else if (exc_return)
        begin
            next_s.current_status_word = s.saved_status_word;
            next_s.cause = EXC_NONE;
        end
        else if (acc && pwrite && paddr == ADDR_STATUS)
        begin
            next_s.current_status_word = pwdata[STATUS_W-1:0];
        end
        else if (acc && pwrite && paddr == ADDR_SAVED)
        begin
            next_s.saved_status_word = pwdata[STATUS_W-1:0];
        end

        if (!mode_valid(next_s.current_status_word[4:0]))
        begin
            next_s.locked = 1'b1;
        end

        // vector follows the entry taken this cycle
        if (next_s.vload)
        begin
            next_s.vaddr = vector_of(next_s.cause);
        end

        // register reads
        next_s.rdata = read_word(paddr, s);
    end

    // --------------------------------------------------------------
    // state register
    // --------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s <= '0;
            s.fsync <= 2'b11;
            s.current_status_word <= STATUS_RESET;
            s.vload <= 1'b1;
            s.vaddr <= VEC_RESET;
            s.cause <= EXC_RESET;
        end
        else
        begin
            s <= next_s;
        end
    end

    // --------------------------------------------------------------
    // outputs
    // --------------------------------------------------------------
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_mapped(paddr);
    assign prdata = s.rdata;
    assign vector_load = s.vload;
    assign vector_addr = s.vaddr;
    assign exc_mode = s.current_status_word[4:0];
    assign data_squash = s.squash;
    assign core_locked = s.locked;

endmodule
`default_nettype wire

// ---- testbench/exc_entry_checker.sv ----
// port assertions for the exception entry unit
`timescale 1ns/1ps
`default_nettype none
module exc_entry_checker
    import exc_entry_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        fast_irq_n,
    input wire logic        instr_end,
    input wire logic        data_abort,
    input wire logic        prefetch_abort_at_exec,
    input wire logic        undef_instr,
    input wire logic        software_trap,
    input wire logic        vector_load,
    input wire logic [31:0] vector_addr,
    input wire logic [4:0]  exc_mode,
    input wire logic        data_squash,
    input wire logic        core_locked
);
    logic quiet;
    logic prev_abort;
    // a fast entry may follow a data abort by one cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prev_abort <= 1'b0;
        else
            prev_abort <= data_abort;
    end
    assign quiet = !instr_end && !core_locked && !data_abort && !prev_abort;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    chk_reset_state: assert property (disable iff (1'b0)
        !presetn |-> vector_load && vector_addr == VEC_RESET
        && exc_mode == MODE_SUPER) else $error("reset state wrong");
    chk_dabort_entry: assert property (data_abort && !core_locked
        |=> vector_load && vector_addr == VEC_DABORT
        && exc_mode == MODE_ABORT && data_squash) else $error("dabort wrong");
    chk_pabort_vector: assert property (prefetch_abort_at_exec && quiet
        |=> vector_load && vector_addr == VEC_PABORT
        && exc_mode == MODE_ABORT) else $error("pabort wrong");
    chk_undef_vector: assert property (undef_instr && !software_trap
        && !prefetch_abort_at_exec && quiet |=> vector_load
        && vector_addr == VEC_UNDEF && exc_mode == MODE_UNDEF)
        else $error("undef wrong");
    chk_trap_vector: assert property (software_trap && quiet
        && !prefetch_abort_at_exec |=> vector_load
        && vector_addr == VEC_TRAP && exc_mode == MODE_SUPER)
        else $error("trap wrong");
    chk_no_reserved: assert property (vector_load
        |-> vector_addr != VEC_RESERVED) else $error("reserved vector used");
    chk_lock_blocks: assert property (core_locked
        |=> core_locked && !vector_load) else $error("locked core moved");
    chk_fast_sync: assert property (instr_end && $past(fast_irq_n)
        && $past(fast_irq_n, 2) |=> !(vector_load && vector_addr == VEC_FAST))
        else $error("fast entry without synchronised level");
    chk_fast_mode: assert property (vector_load
        && vector_addr == VEC_FAST |-> exc_mode == MODE_FAST)
        else $error("fast entry mode wrong");
    chk_squash_abort: assert property (data_squash
        |-> vector_load && vector_addr == VEC_DABORT)
        else $error("squash without data abort");
endmodule
`default_nettype wire

// ---- testbench/irq_source_model.sv ----
// interrupt sources holding active low level requests
`timescale 1ns/1ps
`default_nettype none
module irq_source_model (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic fast_req,
    input  wire logic normal_req,
    output var logic  fast_irq_n,
    output var logic  normal_irq_n
);
    // level held while the cause is pending
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            {fast_irq_n, normal_irq_n} <= 2'b11;
        else
            {fast_irq_n, normal_irq_n} <= {!fast_req, !normal_req};
    end
endmodule
`default_nettype wire

// ---- testbench/tb_top.sv ----
// self-checking bench for the exception entry unit
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import exc_entry_pkg::*;
    logic        pclk = 0, presetn = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, instr_pc = 32'h0000_0100, prdata, vector_addr;
    logic [31:0] rd, vv;
    logic        pready, pslverr, vector_load, data_squash, core_locked, err;
    logic        fast_req = 0, normal_req = 0, fast_irq_n, normal_irq_n;
    logic [5:0]  evs = '0;
    logic [4:0]  exc_mode;
    int          miscompares = 0, samples_checked = 0, cycles = 0;
    logic [39:0] tbl [9] = '{40'h13_1101_7978, 40'h13_20C1_7974,
        40'h13_4041_B9B4, 40'h13_8081_3934, 40'h33_4041_B9B2,
        40'h33_8081_3932, 40'h13_F101_7978, 40'h13_E0C1_7974,
        40'h13_C081_3934};
    exc_entry_unit DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .fast_irq_n, .normal_irq_n,
        .instr_end(evs[4]), .instr_pc, .data_abort(evs[0]),
        .prefetch_abort_at_exec(evs[1]), .undef_instr(evs[2]),
        .software_trap(evs[3]), .exc_return(evs[5]), .vector_load,
        .vector_addr, .exc_mode, .data_squash, .core_locked);
    irq_source_model SRC (.pclk, .presetn, .fast_req, .normal_req,
        .fast_irq_n, .normal_irq_n);
    always #12.5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            end_sim();
        end
    end
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    task end_sim;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task check(input string name, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    endtask
    task pulse(input logic [5:0] ev);
        @(posedge pclk);
        evs <= ev;
        @(posedge pclk);
        evs <= '0;
    endtask
    task wait_vec(input logic [31:0] v, input logic [4:0] m);
        int n;
        n = 0;
        #1;
        while (vector_load !== 1'b1 && n < 5)
        begin
            @(posedge pclk);
            #1;
            n++;
        end
        check("vector load", vector_load, 1'b1);
        check("vector addr", vector_addr, v);
        check("mode", exc_mode, m);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task do_reset;
        @(posedge pclk);
        presetn <= 0;
        repeat (6) @(posedge pclk);
        #1;
        check("reset load", vector_load, 1'b1);
        check("reset vector", vector_addr, VEC_RESET);
        check("reset mode", exc_mode, MODE_SUPER);
        @(posedge pclk);
        presetn <= 1;
        apb(0, ADDR_STATUS, 0);
        check("reset status", rd, 32'h0000_00D3);
        check("unlocked", core_locked, 1'b0);
    endtask
    task t_table;
        logic [39:0] e;
        for (int i = 0; i < 9; i++)
        begin
            e = tbl[i];
            instr_pc <= instr_pc + 32'h0000_0010;
            vv = {24'h0, e[27:20]};
            apb(1, ADDR_STATUS, {24'h0, e[39:32]});
            pulse({2'b00, e[31:28]});
            wait_vec(vv, e[16:12]);
            apb(0, ADDR_STATUS, 0);
            check("status", rd, {24'h0, e[11:4]});
            apb(0, ADDR_SAVED, 0);
            check("saved", rd, {24'h0, e[39:32]});
            apb(0, ADDR_LINK, 0);
            check("link", rd, instr_pc + {28'h0, e[3:0]});
            apb(0, ADDR_VECTOR, 0);
            check("vector reg", rd, vv);
            pulse(6'h20);
            apb(0, ADDR_STATUS, 0);
            check("restored", rd, {24'h0, e[39:32]});
        end
    endtask
    task t_irq;
        for (int k = 0; k < 2; k++)
        begin
            apb(1, ADDR_STATUS, 32'h0000_00D3);
            {fast_req, normal_req} <= k == 0 ? 2'b10 : 2'b01;
            repeat (4) @(posedge pclk);
            pulse(6'h10);
            #1;
            check("masked", vector_load, 1'b0);
            apb(1, ADDR_STATUS, 32'h0000_0013);
            pulse(6'h10);
            vv = k == 0 ? VEC_FAST : VEC_IRQ;
            wait_vec(vv, k == 0 ? MODE_FAST : MODE_IRQ);
            apb(0, ADDR_STATUS, 0);
            check("irq status", rd, k == 0 ? 32'hD1 : 32'h92);
            apb(0, ADDR_LINK, 0);
            check("irq link", rd, instr_pc + 32'h4);
            apb(0, ADDR_PC, 0);
            check("last pc", rd, instr_pc);
            {fast_req, normal_req} <= 2'b00;
        end
    endtask
    task t_abort_fast;
        apb(1, ADDR_STATUS, 32'h0000_0013);
        fast_req <= 1;
        repeat (4) @(posedge pclk);
        pulse(6'h01);
        wait_vec(VEC_DABORT, MODE_ABORT);
        @(posedge pclk);
        wait_vec(VEC_FAST, MODE_FAST);
        apb(0, ADDR_LINK, 0);
        check("nested link", rd, VEC_DABORT + 32'h4);
        apb(0, ADDR_CAUSE, 0);
        check("cause", rd, {29'h0, EXC_FAST});
        fast_req <= 0;
    endtask
    task t_lock;
        apb(1, ADDR_STATUS, 32'h0000_0015);
        apb(0, ADDR_CTRL, 0);
        check("lock bit", rd[0], 1'b1);
        pulse(6'h01);
        #1;
        check("locked entry", vector_load, 1'b0);
        do_reset();
        apb(1, 12'h020, 32'hFFFF_FFFF);
        check("unmapped err", err, 1'b1);
        apb(0, 12'h020, 0);
        check("unmapped data", rd, 32'h0);
    endtask
    initial
    begin
        do_reset();
        t_table();
        t_irq();
        t_abort_fast();
        t_lock();
        end_sim();
    end
endmodule
bind exc_entry_unit exc_entry_checker CHK (.pclk, .presetn, .fast_irq_n,
    .instr_end, .data_abort, .prefetch_abort_at_exec, .undef_instr,
    .software_trap, .vector_load, .vector_addr, .exc_mode, .data_squash,
    .core_locked);
`default_nettype wire
